// *** mcb_bus_unit.sv ***
// Multiplexed bus unit: APB command slave, T-state sequencer, queue
// Assumes pins synchronous to ref_clk; address latch sits outside
//
// Functional notes
// RULE_01 - 1 MB memory, 64K I/O, 16-bit data
// RULE_02 - Each cycle spans at least T1 to T4
// RULE_03 - T1 drives full twenty-bit address
// RULE_04 - T2 drops address; float or drive data
// RULE_05 - Read, write, acknowledge strobes start in T2
// RULE_06 - Max mode delayed write strobe in T3
// RULE_07 - Upper lines carry status from T2
// RULE_08 - Segment status bits encode segment used
// RULE_09 - Interrupt flag status; owner status zero
// RULE_10 - Device flags not ready by T3
// RULE_11 - Wait states repeat T3 until ready
// RULE_12 - Read data taken in last T3/wait
// RULE_13 - T4 drops strobes; device deselects
// RULE_14 - Device latches or releases at strobe end
// RULE_15 - Idle keeps status and write data
// RULE_16 - Six byte queue; flush discards bytes
// RULE_17 - External latch transparent while strobe high
// RULE_18 - Upper byte enable muxed with status; code holds the T1 value all cycle
// RULE_19 - Byte lanes by A0 and enable
// RULE_20 - Odd word splits into two cycles
// RULE_21 - Byte read floats all sixteen lines
// RULE_22 - Byte write drives all sixteen lines
// RULE_23 - Ready sampled each T3/wait clock
`timescale 1ns/100ps
`include "mcb_regs.svh"
module mcb_bus_unit #(
   parameter int QDEPTH = 6
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mcb_pkg::mcb_data_t ad_in,
   output mcb_pkg::mcb_data_t ad_out,
   output logic [15:0] ad_oe,
   output logic [3:0] as_out,
   output logic as_oe,
   output logic upper_byte_enable_n,
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic inta_n,
   output logic mwtc_n,
   output logic io_sel,
   input wire logic ready
);
   import mcb_pkg::*;
   // ****************************************************
   // Command registers
   // ****************************************************
   logic [31:0] ctrl_r;
   mcb_addr_t addr_r;
   mcb_data_t wdata_r;
   mcb_data_t rdata_r;
   logic busy_r;
   logic done_r;
   logic second_r;
   mcb_tstate_t st_r;
   mcb_tstate_t st_nxt;
   logic [3:0] waits_r;
   logic was_write_r;
   mcb_q_if qi ();
   mcb_prefetch_q #(.DEPTH(QDEPTH)) u_q (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .q(qi)
   );
   wire acc = psel && penable;
   wire wr_acc = acc && pwrite;
   wire rd_acc = acc && !pwrite;
   wire sel_ctrl = paddr == `MCB_OFF_CTRL;
   wire sel_addr = paddr == `MCB_OFF_ADDR;
   wire sel_wdat = paddr == `MCB_OFF_WDATA;
   wire sel_stat = paddr == `MCB_OFF_STATUS;
   wire sel_rdat = paddr == `MCB_OFF_RDATA;
   wire sel_que = paddr == `MCB_OFF_QUEUE;
   wire mapped = sel_ctrl | sel_addr | sel_wdat | sel_stat | sel_rdat
      | sel_que;
   wire go = wr_acc && sel_ctrl && pwdata[`MCB_CTRL_GO] && !busy_r;
   wire is_write = ctrl_r[`MCB_CTRL_WRITE];
   wire is_word = ctrl_r[`MCB_CTRL_WORD];
   wire is_io = ctrl_r[`MCB_CTRL_IO];
   wire is_inta = ctrl_r[`MCB_CTRL_INTA];
   wire is_fetch = ctrl_r[`MCB_CTRL_FETCH];
   wire max_mode = ctrl_r[`MCB_CTRL_MAXMODE];
   wire odd_word = is_word && addr_r[0];
   // I/O space wraps at 64K except the second byte of a word at FFFFh; memory at 1 MB
   wire [19:0] cyc_addr = is_io ? {4'h0, addr_r[15:0]} : addr_r; // RULE_01
   // Look ahead so a split word's second T1 already shows addr+1
   wire sec_n = (st_r == MCB_T4) ? (odd_word && !second_r) : second_r;
   // Second half of a split word: next address, lower lane
   wire [19:0] bus_addr = sec_n ? cyc_addr + 20'h1 : cyc_addr; // RULE_20
   wire a0 = bus_addr[0];
   wire ube_n = !((is_word && !sec_n) || a0); // RULE_19
   // Split low byte on upper lane, high byte on lower lane
   wire [15:0] wlane = odd_word ? (second_r ? {8'h00, wdata_r[15:8]}
      : {wdata_r[7:0], 8'h00}) : (a0 ? {wdata_r[7:0], wdata_r[7:0]}
      : wdata_r); // RULE_20 RULE_22
   wire [3:0] status = {1'b0, ctrl_r[`MCB_CTRL_IF],
      ctrl_r[`MCB_CTRL_SEG_LO+1], ctrl_r[`MCB_CTRL_SEG_LO]}; // RULE_08 RULE_09
   wire more = odd_word && !second_r;
   // ****************************************************
   // T-state sequencer
   // ****************************************************
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         MCB_TI: st_nxt = busy_r ? MCB_T1 : MCB_TI;
         MCB_T1: st_nxt = MCB_T2;
         MCB_T2: st_nxt = MCB_T3;
         // Ready looked at once a clock in T3 and each wait
         MCB_T3: st_nxt = ready ? MCB_T4 : MCB_TW; // RULE_11 RULE_23
         MCB_TW: st_nxt = ready ? MCB_T4 : MCB_TW; // RULE_11 RULE_23
         MCB_T4: st_nxt = more ? MCB_T1 : MCB_TI; // RULE_02
         default: st_nxt = MCB_TI;
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         st_r <= MCB_TI;
      else
         st_r <= st_nxt;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         second_r <= 1'b0;
      else if (st_r == MCB_T4)
         second_r <= more; // RULE_20
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         waits_r <= 4'h0;
      else if (st_r == MCB_T1)
         waits_r <= 4'h0;
      else if (st_r == MCB_TW && waits_r != 4'hf)
         waits_r <= waits_r + 4'h1;
   end
   // Read data sampled as the last T3 or wait state ends
   wire capture = (st_r == MCB_T3 || st_r == MCB_TW) && ready
      && !is_write; // RULE_12
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rdata_r <= 16'h0000;
      else if (capture)
      begin
         if (odd_word)
            rdata_r <= second_r ? {ad_in[7:0], rdata_r[7:0]}
               : {rdata_r[15:8], ad_in[15:8]}; // RULE_20
         else if (!is_word)
            rdata_r <= {8'h00, a0 ? ad_in[15:8] : ad_in[7:0]}; // RULE_19
         else
            rdata_r <= ad_in;
      end
   end
   wire push_fetch = capture && is_fetch;
   assign qi.push = push_fetch;
   assign qi.push_byte = a0 ? ad_in[15:8] : ad_in[7:0];
   assign qi.flush = wr_acc && sel_ctrl && pwdata[`MCB_CTRL_FLUSH]; // RULE_16
   assign qi.pop = rd_acc && sel_que;
   // ****************************************************
   // APB command registers
   // ****************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         ctrl_r <= `MCB_RST_CTRL;
      else if (wr_acc && sel_ctrl && !busy_r)
         ctrl_r <= pwdata;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         addr_r <= 20'h00000;
         wdata_r <= 16'h0000;
      end
      else if (wr_acc && !busy_r)
      begin
         if (sel_addr)
            addr_r <= pwdata[19:0];
         if (sel_wdat)
            wdata_r <= pwdata[15:0];
      end
   end
   wire finish = st_r == MCB_T4 && !more;
   // Done set wins over a status read clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         busy_r <= go ? 1'b1 : (finish ? 1'b0 : busy_r);
         // Only a done the read has reported is cleared, else it is lost
         done_r <= finish ? 1'b1
            : ((rd_acc && sel_stat && prdata[1]) ? 1'b0 : done_r);
      end
   end
   wire [31:0] rd_mux = sel_ctrl ? ctrl_r : sel_addr ? {12'h000, addr_r}
      : sel_wdat ? {16'h0000, wdata_r}
      : sel_stat ? {22'h0, waits_r, 1'b0, qi.count, done_r, busy_r}
      : sel_rdat ? {16'h0000, rdata_r}
      : sel_que ? {24'h000000, qi.head} : 32'h0000_0000;
   // Zero wait APB; busy silently refuses writes other than a queue flush
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= rd_mux;
      end
   end
   // ****************************************************
   // Pin drive, registered
   // ****************************************************
   wire n_t1 = st_nxt == MCB_T1;
   wire n_t2 = st_nxt == MCB_T2;
   wire n_t3w = st_nxt == MCB_T3 || st_nxt == MCB_TW;
   wire n_cmd = n_t2 || n_t3w;
   wire n_idle = st_nxt == MCB_TI;
   wire n_data_drv = is_write && !n_t1; // RULE_04 RULE_15 RULE_22
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ad_out <= 16'h0000;
         ad_oe <= 16'h0000;
         as_out <= 4'h0;
         as_oe <= 1'b0;
         upper_byte_enable_n <= 1'b1;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         inta_n <= 1'b1;
         mwtc_n <= 1'b1;
         io_sel <= 1'b0;
         was_write_r <= 1'b0;
      end
      else
      begin
         ale <= n_t1; // RULE_03
         as_oe <= busy_r || was_write_r || !n_idle || as_oe;
         if (n_t1)
         begin
            ad_out <= bus_addr[15:0]; // RULE_03
            ad_oe <= 16'hffff;
            as_out <= bus_addr[19:16]; // RULE_03
            upper_byte_enable_n <= ube_n; // RULE_18
            io_sel <= is_io;
            was_write_r <= is_write;
         end
         else if (!n_idle)
         begin
            // Byte read floats both lanes
            ad_out <= wlane;
            ad_oe <= n_data_drv ? 16'hffff : 16'h0000; // RULE_04 RULE_21
            as_out <= status; // RULE_07
         end
         else
            ad_oe <= was_write_r ? 16'hffff : 16'h0000; // RULE_15
         rd_n <= !(n_cmd && !is_write && !is_inta); // RULE_05
         wr_n <= !(n_cmd && is_write && !is_inta); // RULE_05
         inta_n <= !(n_cmd && is_inta); // RULE_05
         mwtc_n <= !(n_t3w && is_write && max_mode); // RULE_06 RULE_13
      end
   end
   // ****************************************************
   // Checks
   // ****************************************************
   min_four_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T1 |=> st_r == MCB_T2 ##1 st_r == MCB_T3
      ##[1:1000] st_r == MCB_T4) else $error("cycle short"); // RULE_02
   wait_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_r == MCB_T3 || st_r == MCB_TW) && !ready |=> st_r == MCB_TW)
      else $error("ready ignored"); // RULE_23
   ready_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_TW && ready |=> st_r == MCB_T4)
      else $error("no T4 after ready"); // RULE_11
   cmd_t2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T2 && !is_write && !is_inta |-> !rd_n)
      else $error("read strobe late"); // RULE_05
   cmd_t4_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T4 |-> rd_n && wr_n && inta_n && mwtc_n)
      else $error("strobe in T4"); // RULE_13
   status_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T3 |-> as_out == status && !as_out[3])
      else $error("status wrong"); // RULE_07 RULE_09
   read_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T3 && !is_write |-> ad_oe == 16'h0000)
      else $error("read drives bus"); // RULE_21
   addr_t1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T1 |-> ale && ad_out == bus_addr[15:0] && ad_oe == 16'hffff)
      else $error("no address in T1"); // RULE_03
   dly_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_T2 |-> mwtc_n) else $error("delayed write early"); // RULE_06
   idle_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_r == MCB_TI && was_write_r |-> ad_oe == 16'hffff)
      else $error("idle write data lost"); // RULE_15
   c_wait: cover property (@(posedge ref_clk) st_r == MCB_TW);
   c_split: cover property (@(posedge ref_clk) second_r && st_r == MCB_T4);
   c_fetch: cover property (@(posedge ref_clk) push_fetch);
endmodule

// *** mcb_mem_model.sv ***
// Memory device model on the multiplexed address, status and data bus
// Assumes the bus unit pins on one clock; wait_cnt set by the bench
`timescale 1ns/100ps
module mcb_mem_model (
   input wire logic ref_clk,
   input wire mcb_pkg::mcb_data_t ad_out,
   input wire logic [3:0] as_out,
   input wire logic ale,
   input wire logic upper_byte_enable_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [3:0] wait_cnt,
   output mcb_pkg::mcb_data_t ad_in,
   output logic ready
);
   import mcb_pkg::*;
   mcb_data_t mem [0:15];
   mcb_addr_t lat_addr = '0;
   logic lat_ube_n = 1'b1;
   logic [3:0] busy_cnt = '0;
   logic wr_prev = 1'b1;
   mcb_data_t idle_pat = 16'h5a5a;
   initial
   begin
      foreach (mem[i]) mem[i] = '0;
   end
   // Released bus toggles so a stale value never passes for data
   assign ad_in = rd_n ? idle_pat : mem[lat_addr[4:1]];
   // Not ready until wait_cnt strobe clocks have passed
   assign ready = (busy_cnt >= wait_cnt);
   always @(posedge ref_clk)
   begin
      idle_pat <= ~idle_pat;
      if (ale)
      begin
         lat_addr <= {as_out, ad_out};
         lat_ube_n <= upper_byte_enable_n;
      end
      busy_cnt <= (rd_n && wr_n) ? 4'h0 : busy_cnt + 4'h1;
      wr_prev <= wr_n;
      if (wr_n && !wr_prev)
      begin
         if (!lat_addr[0]) mem[lat_addr[4:1]][7:0] <= ad_out[7:0];
         if (!lat_ube_n) mem[lat_addr[4:1]][15:8] <= ad_out[15:8];
      end
   end
endmodule

// *** mcb_pkg.sv ***
// Types shared by the bus unit and its prefetch queue
// Assumes nothing of mcb_regs.svh; only the bus unit and bench include it
package mcb_pkg;
   typedef enum logic [2:0] {
      MCB_TI, MCB_T1, MCB_T2, MCB_T3, MCB_TW, MCB_T4
   } mcb_tstate_t;
   typedef logic [19:0] mcb_addr_t;
   typedef logic [15:0] mcb_data_t;
endpackage

// *** mcb_prefetch_q.sv ***
// Six byte instruction prefetch queue
// Assumes synchronous active low reset on ref_clk
`timescale 1ns/100ps
module mcb_prefetch_q #(
   parameter int DEPTH = 6
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   mcb_q_if.queue q
);
   import mcb_pkg::*;
   logic [7:0] mem_r [DEPTH];
   logic [2:0] rd_r;
   logic [2:0] wr_r;
   logic [2:0] cnt_r;
   wire do_push = q.push && (cnt_r < 3'(DEPTH));
   wire do_pop = q.pop && (cnt_r != 3'h0);
   wire [2:0] rd_inc = (rd_r == 3'(DEPTH - 1)) ? 3'h0 : rd_r + 3'h1;
   wire [2:0] wr_inc = (wr_r == 3'(DEPTH - 1)) ? 3'h0 : wr_r + 3'h1;
   assign q.head = mem_r[rd_r];
   assign q.count = cnt_r;
   always_ff @(posedge ref_clk)
   begin
      if (do_push)
         mem_r[wr_r] <= q.push_byte;
   end
   // Flush drops every byte; storage keeps its contents, so head still shows entry 0
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || q.flush)
      begin
         rd_r <= 3'h0;
         wr_r <= 3'h0;
         cnt_r <= 3'h0;
      end
      else
      begin
         if (do_push)
            wr_r <= wr_inc;
         if (do_pop)
            rd_r <= rd_inc;
         cnt_r <= cnt_r + 3'(do_push) - 3'(do_pop);
      end
   end // RULE_16
   never_over_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cnt_r <= 3'(DEPTH)) else $error("queue overfilled"); // RULE_16
   flush_empty_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q.flush |=> cnt_r == 3'h0) else $error("flush left bytes"); // RULE_16
endmodule

// *** mcb_q_if.sv ***
// Link between the bus unit and the prefetch queue
// Assumes one clock shared by both ends
`timescale 1ns/100ps
interface mcb_q_if;
   logic push;
   logic [7:0] push_byte;
   logic flush;
   logic pop;
   logic [7:0] head;
   logic [2:0] count;
   modport owner (output push, push_byte, flush, pop, input head, count);
   modport queue (input push, push_byte, flush, pop, output head, count);
endinterface

// *** mcb_regs.svh ***
// Offsets, field positions, reset value and timing counts of the bus unit
// Assumes inclusion by bare name from the bus unit and the bench
`ifndef MCB_REGS_SVH
`define MCB_REGS_SVH
// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define MCB_OFF_CTRL 12'h000
`define MCB_OFF_ADDR 12'h004
`define MCB_OFF_WDATA 12'h008
`define MCB_OFF_STATUS 12'h00c
`define MCB_OFF_RDATA 12'h010
`define MCB_OFF_QUEUE 12'h014
// ****************************************************
// Field positions
// ****************************************************
`define MCB_CTRL_GO 0
`define MCB_CTRL_WRITE 1
`define MCB_CTRL_WORD 2
`define MCB_CTRL_IO 3
`define MCB_CTRL_INTA 4
`define MCB_CTRL_IF 5
`define MCB_CTRL_MAXMODE 6
`define MCB_CTRL_FLUSH 7
`define MCB_CTRL_SEG_LO 8
`define MCB_CTRL_FETCH 10
`define MCB_RST_CTRL 32'h0000_0000
// ****************************************************
// Timing counts
// ****************************************************
`define MCB_T_STATE_NS 5
`define MCB_MIN_T_STATES 4
`endif

// *** tb_top.sv ***
// Self-checking bench for the multiplexed bus unit
// Assumes mcb_regs.svh on the include path and the memory model
`timescale 1ns/100ps
`include "mcb_regs.svh"
module tb_top;
   import mcb_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, ale, rd_n, wr_n, inta_n, mwtc_n, io_sel;
   logic ready, as_oe, upper_byte_enable_n, t1_ube;
   mcb_data_t ad_in, ad_out;
   logic [15:0] ad_oe;
   logic [3:0] as_out, st;
   logic [3:0] wait_cnt = '0;
   logic [19:0] t1_addr;
   // Flags: 1 phase fault, 2/3 delayed strobe, 4 ack, 5 io, 6 enable
   logic [7:0] fl = '0;
   logic wr_prev = 1'b1;
   int err_total = 0;
   int checks_done = 0;
   int ale_n = 0;
   int stb_n = 0;
   mcb_bus_unit #(.QDEPTH(6)) mcb_bus_unit_inst (.ref_clk(ref_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .as_out(as_out), .as_oe(as_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .upper_byte_enable_n(upper_byte_enable_n), .inta_n(inta_n),
      .mwtc_n(mwtc_n), .io_sel(io_sel), .ready(ready));
   mcb_mem_model mcb_mem_model_inst (.ref_clk(ref_clk), .ad_out(ad_out),
      .as_out(as_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .upper_byte_enable_n(upper_byte_enable_n), .wait_cnt(wait_cnt),
      .ad_in(ad_in), .ready(ready));
   always #2.5 ref_clk = ~ref_clk;
   // ****************************************************
   // Bus monitor
   // ****************************************************
   always @(posedge ref_clk)
   begin
      if (rst_n)
      begin
         if (ale === 1'b1)
         begin
            ale_n++;
            t1_addr = {as_out, ad_out};
            t1_ube = upper_byte_enable_n;
            if (!(rd_n && wr_n && inta_n)) fl[1] = 1'b1;
         end
         if (!(rd_n && wr_n && inta_n))
         begin
            stb_n++;
            st = as_out;
            if (upper_byte_enable_n !== t1_ube) fl[6] = 1'b1;
            if (io_sel === 1'b1) fl[5] = 1'b1;
         end
         if (rd_n === 1'b0 && ad_oe !== 16'h0000) fl[1] = 1'b1;
         if (wr_n === 1'b0 && ad_oe !== 16'hffff) fl[1] = 1'b1;
         if (mwtc_n === 1'b0) fl[2] = 1'b1;
         if (mwtc_n === 1'b0 && wr_prev === 1'b1) fl[3] = 1'b1;
         if (inta_n === 1'b0) fl[4] = 1'b1;
         wr_prev = wr_n;
      end
   end
   // ****************************************************
   // Bus tasks and scenarios
   // ****************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, '0, q, e);
   endtask
   // Poll of done; the status read clears it; the watchdog ends a hang
   task automatic go(input logic [31:0] c, input logic [19:0] a,
      input logic [15:0] d, output logic [31:0] s);
      wr(`MCB_OFF_ADDR, {12'h000, a});
      wr(`MCB_OFF_WDATA, {16'h0000, d});
      fl = '0;
      ale_n = 0;
      stb_n = 0;
      wr(`MCB_OFF_CTRL, c | 32'h1);
      s = '0;
      while (s[1] !== 1'b1)
         rd(`MCB_OFF_STATUS, s);
   endtask
   task automatic t_reset();
      logic [31:0] q;
      logic e;
      rd(`MCB_OFF_CTRL, q);
      chk(q, `MCB_RST_CTRL);
      apb(1'b0, 12'h020, '0, q, e);
      chk({q, e}, 33'h1);
      chk({rd_n, wr_n, inta_n, as_oe, ad_oe}, {3'b111, 17'h0});
   endtask
   task automatic t_word();
      logic [31:0] s, q;
      go(32'h6, 20'h0000a, 16'hbeef, s);
      chk({s[1], s[9:6], fl}, {1'b1, 12'h0});
      chk(stb_n, 2);
      chk(ale_n, 1);
      chk({t1_addr, t1_ube}, {20'h0000a, 1'b0});
      chk({ad_oe, ad_out}, {16'hffff, 16'hbeef});
      chk(as_oe, 1);
      go(32'h4, 20'h0000a, 16'h0, s);
      rd(`MCB_OFF_RDATA, q);
      chk(q[15:0], 16'hbeef);
      chk({stb_n, fl}, {32'd2, 8'h0});
      chk({ad_oe, as_out}, {16'h0, st});
   endtask
   task automatic t_odd();
      logic [31:0] s, q;
      go(32'h6, 20'h10013, 16'h1234, s);
      chk(ale_n, 2);
      chk({t1_addr, t1_ube}, {20'h10014, 1'b1});
      chk(mcb_mem_model_inst.mem[9][15:8], 8'h34);
      chk(mcb_mem_model_inst.mem[10][7:0], 8'h12);
      go(32'h4, 20'h10013, 16'h0, s);
      rd(`MCB_OFF_RDATA, q);
      chk({q[15:0], ale_n[3:0]}, {16'h1234, 4'd2});
   endtask
   task automatic t_byte();
      logic [31:0] s, q;
      go(32'h6, 20'h0000a, 16'h5566, s);
      go(32'h2, 20'h0000b, 16'h00ab, s);
      chk({t1_addr[0], t1_ube, fl[1]}, 3'b100);
      chk(mcb_mem_model_inst.mem[5], 16'hab66);
      go(32'h0, 20'h0000b, 16'h0, s);
      rd(`MCB_OFF_RDATA, q);
      chk({q[7:0], fl[1]}, {8'hab, 1'b0});
   endtask
   task automatic t_wait();
      logic [31:0] s, q;
      wait_cnt <= 4'h3;
      go(32'h4, 20'h0000a, 16'h0, s);
      rd(`MCB_OFF_RDATA, q);
      chk(q[15:0], 16'hab66);
      // Ready on the fourth strobe clock: T3 plus two waits
      chk(s[9:6], 4'h2);
      chk(stb_n, 2 + s[9:6]);
      wait_cnt <= 4'h0;
   endtask
   task automatic t_status();
      logic [31:0] s, c;
      int i;
      for (i = 0; i < 4; i++)
      begin
         c = {22'h0, i[1:0], 8'h04} | (i[0] ? 32'h20 : 32'h0);
         c = c | ((i == 3) ? 32'h8 : 32'h0);
         go(c, 20'h0000a, 16'h0, s);
         chk(st, {1'b0, i[0], i[1], i[0]});
         chk(fl[5], i == 3);
      end
   endtask
   task automatic t_cmd_q();
      logic [31:0] s, q;
      go(32'h46, 20'h0000c, 16'h7777, s);
      chk(fl[3:2], 2'b01);
      go(32'h14, 20'h00000, 16'h0, s);
      chk(fl[4], 1);
      go(32'h400, 20'h0000a, 16'h0, s);
      chk(s[4:2], 1);
      rd(`MCB_OFF_QUEUE, q);
      chk(q[7:0], 8'h66);
      go(32'h400, 20'h0000a, 16'h0, s);
      wr(`MCB_OFF_CTRL, 32'h80);
      rd(`MCB_OFF_STATUS, s);
      chk(s[4:2], 0);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_word();
      t_odd();
      t_byte();
      t_wait();
      t_status();
      t_cmd_q();
      tally_and_finish();
   end
   // Whole run needs a few hundred clocks; this allows ample margin
   initial
   begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule
